// *** design/scg_pkg.sv ***
// Shared constants of the system clock select and gear block
package scg_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] SRC_SEL_OFS  = 8'h00;
  localparam logic [7:0] OSC_CTL_OFS  = 8'h04;
  localparam logic [7:0] WAIT_ON_OFS  = 8'h08;
  localparam logic [7:0] RC_CTL_OFS   = 8'h0c;
  localparam logic [7:0] GEAR_CTL_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS   = 8'h14;

  // Oscillator indices
  localparam int OSC_N    = 3;
  localparam int RC_IDX   = 0;
  localparam int SLOW_IDX = 1;
  localparam int FAST_IDX = 2;

  // Source selector codes
  localparam logic [1:0] SRC_RC   = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_FAST = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;

  // Field positions in the oscillator control register
  localparam int RC_ON_BIT   = 0;
  localparam int FAST_ON_BIT = 1;
  localparam int SLOW_ON_BIT = 2;
  localparam int RC_WT_LSB   = 4;
  localparam int FAST_WT_LSB = 6;

  // Field positions in the wait circuit enable register
  localparam int FAST_WCE_BIT = 0;
  localparam int SLOW_WCE_BIT = 1;

  // Field positions in the status register
  localparam int STAT_RDY_LSB  = 0;
  localparam int STAT_HALT_BIT = 4;
  localparam int STAT_SLP_BIT  = 5;

  // Reset values
  localparam logic [1:0] RC_FREQ_RST = 2'h1;
  localparam logic [1:0] RC_WT_RST   = 2'h0;
  localparam logic [1:0] FAST_WT_RST = 2'h0;
  localparam logic [1:0] GEAR_RST    = 2'h0;

  // Stabilisation wait counts, in oscillator cycles
  localparam int WAIT_W = 11;
  localparam logic [WAIT_W-1:0] RC_WAIT_BASE   = 11'h008;
  localparam logic [WAIT_W-1:0] FAST_WAIT_BASE = 11'h080;
  localparam logic [WAIT_W-1:0] SLOW_WAIT      = 11'h100;

  // Width of the gear divider limit for codes 0..3 (ratio minus one)
  localparam int GEAR_W = 3;

endpackage : scg_pkg

// *** design/scg_osc_if.sv ***
// Signals between the clock block and one oscillator wait unit
`timescale 1ns/1ps
`default_nettype none
interface scg_osc_if;
  import scg_pkg::*;
  logic              run;
  logic              tick;
  logic              wait_on;
  logic [WAIT_W-1:0] wait_cnt;
  logic              ready;

  modport ctrl (output run, output tick, output wait_on, output wait_cnt, input ready);
  modport unit (input run, input tick, input wait_on, input wait_cnt, output ready);
endinterface : scg_osc_if
`default_nettype wire

// *** design/scg_osc_wait.sv ***
// Oscillation stabilisation wait counter for one oscillator
`timescale 1ns/1ps
`default_nettype none
module scg_osc_wait (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  scg_osc_if.unit    osc
);
  import scg_pkg::*;

  logic [WAIT_W-1:0] cnt;
  logic [WAIT_W-1:0] next_cnt;
  logic              rdy;
  logic              next_rdy;

  // Count oscillator cycles after start; a stop restarts the wait
  always_comb begin
    next_cnt = cnt;
    next_rdy = rdy;
    if (!osc.run) begin
      next_cnt = '0;
      next_rdy = 1'b0;
    end else if (!osc.wait_on) begin
      next_rdy = 1'b1;
    end else if (osc.tick && !rdy) begin
      next_cnt = cnt + 1'b1;
      if (next_cnt >= osc.wait_cnt) begin
        next_rdy = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      rdy <= 1'b0;
    end else begin
      cnt <= next_cnt;
      rdy <= next_rdy;
    end
  end

  // Clock withheld until ready
  assign osc.ready = rdy;

endmodule : scg_osc_wait
`default_nettype wire

// *** design/scg_clock_gen.sv ***
// System clock source select, stabilisation waits, core gear and halt/sleep
// Operation
// - Two-bit RC frequency select, resets to 1
// - RC runs when enabled, stops in sleep
// - RC variant resets with RC enabled, selected
// - Sleep exit forces RC on and selected
// - RC start wait 64/32/16/8 cycles by code
// - Two-bit source selector, 3 reserved
// - Reset source: fast crystal or RC by variant
// - Selecting a stopped oscillator is ignored
// - Selected oscillator cannot be switched off
// - Halt exit keeps oscillator and source setup
// - Core gear divides by 1/2/4/8
// - Halt stops core clock only
// - Reset or any interrupt ends halt
// - Sleep stops all clocks; external interrupt wakes
// - Fast crystal wait 128..1024 cycles by code
// - Slow crystal fixed 256-cycle start wait
// - Crystal wait circuits enabled at reset, bypassable
`timescale 1ns/1ps
`default_nettype none
module scg_clock_gen #(
  parameter bit HAS_RC = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Oscillator outputs as seen on pins, asynchronous to clk_i
  input  wire logic        rc_osc_clk_i,
  input  wire logic        slow_crystal_osc_clk_i,
  input  wire logic        fast_crystal_osc_clk_i,
  // Core and interrupt events, same clock
  input  wire logic        halt_req_i,
  input  wire logic        sleep_req_i,
  input  wire logic        nmi_i,
  input  wire logic        irq_i,
  input  wire logic        ext_irq_i,
  // Oscillator controls
  output logic             rc_osc_run_o,
  output logic             slow_xtal_run_o,
  output logic             fast_xtal_run_o,
  output logic      [1:0]  rc_freq_select_o,
  // Generated clock enables
  output logic             sysclk_en_o,
  output logic             core_clock_en_o
);
  import scg_pkg::*;

  // Control state
  logic [1:0] sysclk_source_select, next_sysclk_source_select;
  logic [2:0] osc_on, next_osc_on;               // Indexed by oscillator
  logic [1:0] rc_wait_select, next_rc_wait_select;
  logic [1:0] fast_xtal_wait_select, next_fast_xtal_wait_select;
  logic       fast_xtal_wait_on, next_fast_xtal_wait_on;
  logic       slow_xtal_wait_on, next_slow_xtal_wait_on;
  logic [1:0] rc_freq_select, next_rc_freq_select;
  logic [1:0] core_gear_select, next_core_gear_select;
  logic       halted, next_halted;
  logic       sleeping, next_sleeping;

  // Bus state
  logic        ack, next_ack;
  logic [31:0] rdata, next_rdata;

  // Clock state
  logic [GEAR_W-1:0] gear_cnt, next_gear_cnt;
  logic [GEAR_W-1:0] gear_lim, next_gear_lim;
  logic              sys_en, next_sys_en;
  logic              core_en, next_core_en;

  // Pin synchronisers and edge detection
  logic [OSC_N-1:0] osc_pin;
  logic [OSC_N-1:0] sync1, sync2, sync3;
  logic [OSC_N-1:0] tick;
  logic [OSC_N-1:0] ready;
  logic [OSC_N-1:0] run;

  // Request decode
  logic wr_req;
  logic rd_req;

  assign osc_pin = {fast_crystal_osc_clk_i, slow_crystal_osc_clk_i, rc_osc_clk_i};
  // Two flops before any logic, third flop only for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= osc_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign tick = sync2 & ~sync3;
  assign run = osc_on & {OSC_N{~sleeping}};

  // One wait unit per oscillator
  genvar gi;
  generate
    for (gi = 0; gi < OSC_N; gi++) begin : g_osc
      scg_osc_if oif ();
      assign oif.run  = run[gi];
      assign oif.tick = tick[gi];
      if (gi == RC_IDX) begin : g_rc
        assign oif.wait_on  = 1'b1;
        assign oif.wait_cnt = RC_WAIT_BASE << (2'h3 - rc_wait_select);
      end else if (gi == FAST_IDX) begin : g_fast
        assign oif.wait_on  = fast_xtal_wait_on;
        assign oif.wait_cnt = FAST_WAIT_BASE << (2'h3 - fast_xtal_wait_select);
      end else begin : g_slow
        assign oif.wait_on  = slow_xtal_wait_on;
        assign oif.wait_cnt = SLOW_WAIT;
      end
      assign ready[gi] = oif.ready;
      scg_osc_wait u_wait (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .osc   (oif.unit)
      );
    end
  endgenerate
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !ack;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !ack;

  // Register writes, mode changes and the guarded source switch
  always_comb begin
    logic [1:0] req_src;
    logic       src_ok;
    logic [2:0] req_on;
    req_src = wb_dat_i[1:0];
    src_ok  = 1'b0;
    req_on  = osc_on;
    next_sysclk_source_select  = sysclk_source_select;
    next_osc_on                = osc_on;
    next_rc_wait_select        = rc_wait_select;
    next_fast_xtal_wait_select = fast_xtal_wait_select;
    next_fast_xtal_wait_on     = fast_xtal_wait_on;
    next_slow_xtal_wait_on     = slow_xtal_wait_on;
    next_rc_freq_select        = rc_freq_select;
    next_core_gear_select      = core_gear_select;
    next_halted                = halted;
    next_sleeping              = sleeping;
    if (wr_req && wb_sel_i[0]) begin
      case (wb_adr_i)
        SRC_SEL_OFS: begin
          case (req_src)
            SRC_RC:   src_ok = HAS_RC && osc_on[RC_IDX];
            SRC_SLOW: src_ok = osc_on[SLOW_IDX];
            SRC_FAST: src_ok = osc_on[FAST_IDX];
            default:  src_ok = 1'b0;
          endcase
          if (src_ok) begin
            next_sysclk_source_select = req_src;
          end
        end
        OSC_CTL_OFS: begin
          req_on[RC_IDX]   = wb_dat_i[RC_ON_BIT] && HAS_RC;
          req_on[FAST_IDX] = wb_dat_i[FAST_ON_BIT];
          req_on[SLOW_IDX] = wb_dat_i[SLOW_ON_BIT];
          case (sysclk_source_select)
            SRC_RC:   req_on[RC_IDX]   = 1'b1;
            SRC_SLOW: req_on[SLOW_IDX] = 1'b1;
            SRC_FAST: req_on[FAST_IDX] = 1'b1;
            default:  req_on = req_on;
          endcase
          next_osc_on                = req_on;
          next_rc_wait_select        = wb_dat_i[RC_WT_LSB +: 2];
          next_fast_xtal_wait_select = wb_dat_i[FAST_WT_LSB +: 2];
        end
        WAIT_ON_OFS: begin
          next_fast_xtal_wait_on = wb_dat_i[FAST_WCE_BIT];
          next_slow_xtal_wait_on = wb_dat_i[SLOW_WCE_BIT];
        end
        RC_CTL_OFS:   next_rc_freq_select   = wb_dat_i[1:0];
        GEAR_CTL_OFS: next_core_gear_select = wb_dat_i[1:0];
        default:      next_halted = halted;
      endcase
    end
    if (halt_req_i && !sleeping) begin
      next_halted = 1'b1;
    end
    // Any interrupt ends halt; setup left intact
    if (halted && (nmi_i || irq_i || ext_irq_i)) begin
      next_halted = 1'b0;
    end
    if (sleep_req_i) begin
      next_sleeping = 1'b1;
    end
    if (sleeping && ext_irq_i) begin
      next_sleeping = 1'b0;
      next_halted   = 1'b0;
      if (HAS_RC) begin
        next_osc_on[RC_IDX]       = 1'b1;
        next_sysclk_source_select = SRC_RC;
      end
    end
  end

  // Read data and one-cycle acknowledge; unmapped reads give zero
  always_comb begin
    next_ack   = wb_cyc_i && wb_stb_i && !ack;
    next_rdata = rdata;
    if (rd_req) begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
        SRC_SEL_OFS:  next_rdata[1:0] = sysclk_source_select;
        OSC_CTL_OFS: begin
          next_rdata[RC_ON_BIT]         = osc_on[RC_IDX];
          next_rdata[FAST_ON_BIT]       = osc_on[FAST_IDX];
          next_rdata[SLOW_ON_BIT]       = osc_on[SLOW_IDX];
          next_rdata[RC_WT_LSB +: 2]    = rc_wait_select;
          next_rdata[FAST_WT_LSB +: 2]  = fast_xtal_wait_select;
        end
        WAIT_ON_OFS: begin
          next_rdata[FAST_WCE_BIT] = fast_xtal_wait_on;
          next_rdata[SLOW_WCE_BIT] = slow_xtal_wait_on;
        end
        RC_CTL_OFS:   next_rdata[1:0] = rc_freq_select;
        GEAR_CTL_OFS: next_rdata[1:0] = core_gear_select;
        STATUS_OFS: begin
          next_rdata[STAT_RDY_LSB +: OSC_N] = ready;
          next_rdata[STAT_HALT_BIT]         = halted;
          next_rdata[STAT_SLP_BIT]          = sleeping;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // System tick and geared core tick
  always_comb begin
    logic sel_tick;
    sel_tick = 1'b0;
    case (sysclk_source_select)
      SRC_RC:   sel_tick = tick[RC_IDX] && ready[RC_IDX];
      SRC_SLOW: sel_tick = tick[SLOW_IDX] && ready[SLOW_IDX];
      SRC_FAST: sel_tick = tick[FAST_IDX] && ready[FAST_IDX];
      default:  sel_tick = 1'b0;
    endcase
    // Whole source periods only, no runts
    next_sys_en   = sel_tick && !sleeping;
    next_gear_cnt = gear_cnt;
    next_gear_lim = gear_lim;
    next_core_en  = 1'b0;
    if (next_sys_en) begin
      if (gear_cnt == gear_lim) begin
        next_gear_cnt = '0;
        // Gear ratio; new ratio only at wrap
        next_gear_lim = GEAR_W'((4'h1 << core_gear_select) - 4'h1);
      end else begin
        next_gear_cnt = gear_cnt + 1'b1;
      end
      next_core_en = (gear_cnt == '0) && !halted;
    end
  end

  // Registers of all state groups
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sysclk_source_select  <= HAS_RC ? SRC_RC : SRC_FAST;
      osc_on                <= HAS_RC ? 3'h1 : 3'h4;
      rc_wait_select        <= RC_WT_RST;
      fast_xtal_wait_select <= FAST_WT_RST;
      fast_xtal_wait_on     <= 1'b1;
      slow_xtal_wait_on     <= 1'b1;
      rc_freq_select        <= RC_FREQ_RST;
      core_gear_select      <= GEAR_RST;
      halted                <= 1'b0;
      sleeping              <= 1'b0;
      ack                   <= 1'b0;
      rdata                 <= 32'h0000_0000;
      gear_cnt              <= '0;
      gear_lim              <= '0;
      sys_en                <= 1'b0;
      core_en               <= 1'b0;
    end else begin
      sysclk_source_select  <= next_sysclk_source_select;
      osc_on                <= next_osc_on;
      rc_wait_select        <= next_rc_wait_select;
      fast_xtal_wait_select <= next_fast_xtal_wait_select;
      fast_xtal_wait_on     <= next_fast_xtal_wait_on;
      slow_xtal_wait_on     <= next_slow_xtal_wait_on;
      rc_freq_select        <= next_rc_freq_select;
      core_gear_select      <= next_core_gear_select;
      halted                <= next_halted;
      sleeping              <= next_sleeping;
      ack                   <= next_ack;
      rdata                 <= next_rdata;
      gear_cnt              <= next_gear_cnt;
      gear_lim              <= next_gear_lim;
      sys_en                <= next_sys_en;
      core_en               <= next_core_en;
    end
  end

  // Outputs from flops; oscillator run outputs are osc_on gated by sleeping
  assign wb_ack_o         = ack;
  assign wb_dat_o         = rdata;
  assign rc_osc_run_o     = run[RC_IDX];
  assign slow_xtal_run_o  = run[SLOW_IDX];
  assign fast_xtal_run_o  = run[FAST_IDX];
  assign rc_freq_select_o = rc_freq_select;
  assign sysclk_en_o      = sys_en;
  assign core_clock_en_o  = core_en;
endmodule : scg_clock_gen
`default_nettype wire

// *** test/scg_osc_model.sv ***
// Behavioural oscillator standing in for one clock source pin
`timescale 1ns/1ps
`default_nettype none
module scg_osc_model #(
  parameter int HALF_NS = 100
) (
  input  wire logic run_i,
  output var  logic clk_o
);
  // oscillates only while run
  // Stands low when stopped, so a stale edge never reaches the block
  initial begin
    clk_o = 1'b0;
    forever begin
      #(HALF_NS);
      clk_o = run_i ? ~clk_o : 1'b0;
    end
  end
endmodule : scg_osc_model
`default_nettype wire

// *** test/scg_clock_gen_sva.sv ***
// Port-level checks for the clock select and gear block
`timescale 1ns/1ps
`default_nettype none
module scg_clock_gen_sva #(
  parameter bit HAS_RC = 1'b1
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       halt_req_i,
  input wire logic       sleep_req_i,
  input wire logic       nmi_i,
  input wire logic       irq_i,
  input wire logic       ext_irq_i,
  input wire logic       rc_osc_run_o,
  input wire logic       slow_xtal_run_o,
  input wire logic       fast_xtal_run_o,
  input wire logic [1:0] rc_freq_select_o,
  input wire logic       sysclk_en_o,
  input wire logic       core_clock_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Any interrupt ends halt
  logic wake_any;
  assign wake_any = nmi_i | irq_i | ext_irq_i;

  // Track halt and sleep from the core's requests
  logic halted;
  logic asleep;
  logic next_halted;
  logic next_asleep;
  always_comb begin
    next_halted = halt_req_i ? 1'b1 : (wake_any ? 1'b0 : halted);
    next_asleep = sleep_req_i ? 1'b1 : (ext_irq_i ? 1'b0 : asleep);
  end
  always_ff @(posedge clk_i) begin
    halted <= rst_i ? 1'b0 : next_halted;
    asleep <= rst_i ? 1'b0 : next_asleep;
  end

  // Allow a few cycles for pulses already in the pipeline to drain
  sequence halt_held_s;
    halt_req_i ##1 !wake_any [*3];
  endsequence
  sequence sleep_held_s;
    sleep_req_i ##1 !ext_irq_i [*6];
  endsequence

  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus request not acknowledged for exactly one cycle");
  reset_source_a: assert property ($fell(rst_i) |-> !slow_xtal_run_o &&
    (HAS_RC ? (rc_osc_run_o && !fast_xtal_run_o) : (fast_xtal_run_o && !rc_osc_run_o)))
    else $error("wrong oscillator running after reset");
  reset_freq_a: assert property ($fell(rst_i) |-> rc_freq_select_o == 2'h1)
    else $error("rc frequency code wrong after reset");
  sleep_stop_a: assert property (sleep_held_s |->
    !rc_osc_run_o && !slow_xtal_run_o && !fast_xtal_run_o && !sysclk_en_o && !core_clock_en_o)
    else $error("clocks still running in sleep");
  sleep_wake_a: assert property (HAS_RC && asleep && ext_irq_i |-> ##[1:2] rc_osc_run_o)
    else $error("rc oscillator not restarted on wake");
  halt_core_a: assert property (halt_held_s |-> !core_clock_en_o)
    else $error("core clock running in halt");
  halt_keep_a: assert property (halted |-> $stable({rc_osc_run_o, slow_xtal_run_o, fast_xtal_run_o}))
    else $error("oscillator state changed in halt");
  core_in_sys_a: assert property (core_clock_en_o |-> sysclk_en_o)
    else $error("core pulse without system pulse");
endmodule : scg_clock_gen_sva

bind scg_clock_gen scg_clock_gen_sva #(.HAS_RC(HAS_RC)) u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .halt_req_i, .sleep_req_i, .nmi_i, .irq_i, .ext_irq_i, .rc_osc_run_o, .slow_xtal_run_o,
  .fast_xtal_run_o, .rc_freq_select_o, .sysclk_en_o, .core_clock_en_o);
`default_nettype wire

// *** test/system_clock_select_and_gear_tb.sv ***
// Self-checking bench for the clock select and gear block
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_and_gear_tb;
  import scg_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, rc_osc_clk_i, slow_crystal_osc_clk_i, fast_crystal_osc_clk_i;
  logic halt_req_i = 1'b0, sleep_req_i = 1'b0, nmi_i = 1'b0, irq_i = 1'b0, ext_irq_i = 1'b0;
  logic rc_osc_run_o, slow_xtal_run_o, fast_xtal_run_o, sysclk_en_o, core_clock_en_o;
  logic [1:0] rc_freq_select_o;
  int n_errors = 0, compares = 0, ticks = 0, rnd, nc, b;
  int e [3];

  scg_clock_gen uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .rc_osc_clk_i, .slow_crystal_osc_clk_i, .fast_crystal_osc_clk_i, .halt_req_i,
    .sleep_req_i, .nmi_i, .irq_i, .ext_irq_i, .rc_osc_run_o, .slow_xtal_run_o, .fast_xtal_run_o,
    .rc_freq_select_o, .sysclk_en_o, .core_clock_en_o);
  scg_osc_model #(.HALF_NS(83)) u_rc (.run_i(rc_osc_run_o), .clk_o(rc_osc_clk_i));
  scg_osc_model #(.HALF_NS(173)) u_slow (.run_i(slow_xtal_run_o), .clk_o(slow_crystal_osc_clk_i));
  scg_osc_model #(.HALF_NS(101)) u_fast (.run_i(fast_xtal_run_o), .clk_o(fast_crystal_osc_clk_i));

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // Pin edge counts, the yardstick for every stabilisation wait
  always @(posedge rc_osc_clk_i) e[RC_IDX]++;
  always @(posedge slow_crystal_osc_clk_i) e[SLOW_IDX]++;
  always @(posedge fast_crystal_osc_clk_i) e[FAST_IDX]++;

  // Cut a hang short; the whole run needs well under this
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 60000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic cycle: hold everything until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  // Write, then an unrelated access (unmapped, reads 0), then read back
  task automatic refuse(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    wr(a, d);
    rd(8'h20, 32'h0);
    rd(a, exp);
  endtask : refuse

  // Edges since base until the first system pulse, with slack for synchronisers
  task automatic first_pulse(input int which, input int base, input int w);
    int d;
    do @(negedge clk_i); while (sysclk_en_o !== 1'b1);
    d = e[which] - base;
    chk({31'h0, d >= w && d <= w + 3}, 32'h1);
  endtask : first_pulse

  // Restart one oscillator from off, select it and time its wait
  task automatic measure(input logic [1:0] pre, input logic [31:0] off_c, input logic [31:0] on_c,
                         input logic [1:0] src, input int which, input int w);
    int base;
    wr(SRC_SEL_OFS, {30'h0, pre});
    wr(OSC_CTL_OFS, off_c);
    base = e[which];
    wr(OSC_CTL_OFS, on_c);
    wr(SRC_SEL_OFS, {30'h0, src});
    repeat (4) @(posedge clk_i);
    first_pulse(which, base, w);
  endtask : measure

  task automatic count(input int ns, output int ncore);
    int k;
    k = 0;
    ncore = 0;
    while (k < ns) begin
      @(negedge clk_i);
      k += (sysclk_en_o === 1'b1);
      ncore += (core_clock_en_o === 1'b1);
    end
  endtask : count

  // One-cycle pulse on halt, sleep, nmi, irq or external interrupt
  task automatic pulse(input int k);
    @(posedge clk_i);
    {ext_irq_i, irq_i, nmi_i, sleep_req_i, halt_req_i} <= 5'h1 << k;
    @(posedge clk_i);
    {ext_irq_i, irq_i, nmi_i, sleep_req_i, halt_req_i} <= 5'h0;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  // Main sequence
  initial begin
    rnd = $urandom(34);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    first_pulse(RC_IDX, e[RC_IDX], 64);
    rd(SRC_SEL_OFS, 32'h0);
    rd(OSC_CTL_OFS, 32'h1);
    rd(WAIT_ON_OFS, 32'h3);
    rd(RC_CTL_OFS, 32'h1);
    rd(GEAR_CTL_OFS, 32'h0);
    rd(STATUS_OFS, 32'h1);
    rnd = $urandom % 4;
    refuse(RC_CTL_OFS, rnd, rnd);
    chk({30'h0, rc_freq_select_o}, rnd);
    refuse(8'h24, 32'h5a, 32'h0);
    for (int c = 0; c < 4; c++) begin
      measure(SRC_RC, 32'h1 | (c << 6), 32'h3 | (c << 6), SRC_FAST, FAST_IDX, 128 << (3 - c));
    end
    for (int c = 0; c < 4; c++) begin
      measure(SRC_FAST, 32'h2, 32'h3 | (c << 4), SRC_RC, RC_IDX, 8 << (3 - c));
    end
    measure(SRC_RC, 32'h1, 32'h5, SRC_SLOW, SLOW_IDX, 256);
    wr(WAIT_ON_OFS, 32'h1);
    measure(SRC_RC, 32'h1, 32'h5, SRC_SLOW, SLOW_IDX, 0);
    refuse(SRC_SEL_OFS, SRC_FAST, 32'h1);
    refuse(SRC_SEL_OFS, SRC_RSVD, 32'h1);
    refuse(OSC_CTL_OFS, 32'h1, 32'h5);
    wr(SRC_SEL_OFS, SRC_RC);
    for (int i = 0; i < 7; i++) begin
      rnd = (i < 4) ? i : $urandom % 4;
      wr(GEAR_CTL_OFS, rnd);
      count(16, nc);
      count(32, nc);
      chk(nc, 32 >> rnd);
    end
    wr(GEAR_CTL_OFS, 32'h0);
    for (int j = 2; j < 5; j++) begin
      pulse(0);
      count(16, nc);
      chk(nc, 0);
      rd(STATUS_OFS, 32'h13);
      pulse(j);
      count(16, nc);
      chk(nc, 16);
      rd(OSC_CTL_OFS, 32'h5);
    end
    wr(SRC_SEL_OFS, SRC_SLOW);
    pulse(1);
    repeat (6) @(posedge clk_i);
    chk({29'h0, rc_osc_run_o, slow_xtal_run_o, fast_xtal_run_o}, 32'h0);
    nc = 0;
    repeat (200) begin
      @(negedge clk_i);
      nc += (sysclk_en_o === 1'b1);
    end
    chk(nc, 0);
    b = e[RC_IDX];
    pulse(4);
    chk({31'h0, rc_osc_run_o}, 32'h1);
    first_pulse(RC_IDX, b, 64);
    rd(SRC_SEL_OFS, 32'h0);
    // Reset in mid-run while halted: halt must end and the RC wait run again
    pulse(0);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    b = e[RC_IDX];
    first_pulse(RC_IDX, b, 64);
    count(8, nc);
    chk(nc, 8);
    rd(STATUS_OFS, 32'h1);
    rd(OSC_CTL_OFS, 32'h1);
    print_verdict();
  end
endmodule : system_clock_select_and_gear_tb
`default_nettype wire
